/* File: design/rbm_consts.vh */
// What this block does
// - Code 10 interleaves four channels byte-wise
// - Code 10 sync high four bit times
// - H.100 sync high two bit times
// - Sync marks combined multiplexed frame boundary
// - Data bits launched on clock rising edge
`ifndef RBM_CONSTS_VH
`define RBM_CONSTS_VH
`define RBM_ADDR_RECEIVE_INTERFACE_CONTROL      12'h000
`define RBM_ADDR_STATUS    12'h004
`define RBM_MODE_LSB       0
`define RBM_MODE_MSB       1
`define RBM_MUXEN_BIT      2
`define RBM_RECEIVE_INTERFACE_CONTROL_RESET     8'h00
`define RBM_MODE_HMVIP     2'h2
`define RBM_MODE_H100      2'h3
`define RBM_FRAME_BITS     12'h800
`define RBM_FRAME_LAST     12'h7FF
`define RBM_HMVIP_PRE      12'h7FE
`define RBM_H100_PRE       12'h7FF
`define RBM_HMVIP_POST     12'h001
`define RBM_H100_POST      12'h000
`define RBM_CH_COUNT       2'h3
`define RBM_BIT_LAST       3'h7
`endif

/* File: design/rbm_rx_backplane_mux.v */
`timescale 1ns/1ps
`include "rbm_consts.vh"
module rbm_rx_backplane_mux (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        clkEn,
  input  wire [31:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_serial_clock,
  input  wire [7:0]  chByte0,
  input  wire [7:0]  chByte1,
  input  wire [7:0]  chByte2,
  input  wire [7:0]  chByte3,
  input  wire        chValid,
  output wire        chReady,
  output reg         rx_serial_out,
  output reg         rx_frame_sync
);
  reg  [7:0]  receive_interface_control_q;
  reg  [2:0]  clkSync_q;
  reg  [31:0] buf0_q;
  reg  [31:0] buf1_q;
  reg  [1:0]  bufCnt_q;
  reg  [11:0] bitPos_q;
  reg  [31:0] shift_q;
  reg         underrun_q;
  wire [1:0]  rxModeSel;
  wire        muxEn;
  wire        modeOk;
  wire        wordDone;
  wire        pop;
  wire        push;
  wire        apbWrite;
  wire        addrOk;
  wire [11:0] nextPos;
  wire [11:0] preStart;
  wire [11:0] postEnd;
  wire        syncNext;

  assign rxModeSel = receive_interface_control_q[`RBM_MODE_MSB:`RBM_MODE_LSB];
  assign muxEn     = receive_interface_control_q[`RBM_MUXEN_BIT];
  // Reserved codes leave the output idle
  assign modeOk    = muxEn && rxModeSel[1];
  assign addrOk    = (paddr[11:0] == `RBM_ADDR_RECEIVE_INTERFACE_CONTROL) ||
                     (paddr[11:0] == `RBM_ADDR_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addrOk;
  assign apbWrite  = psel && penable && pwrite &&
                     (paddr[11:0] == `RBM_ADDR_RECEIVE_INTERFACE_CONTROL);

  always @* begin
    prdata = 32'h0000_0000;
    if (paddr[11:0] == `RBM_ADDR_RECEIVE_INTERFACE_CONTROL)
      prdata = {24'h000000, receive_interface_control_q};
    else if (paddr[11:0] == `RBM_ADDR_STATUS)
      prdata = {29'h0, underrun_q, bufCnt_q};
  end

  // Second stage high and third stage low mark a rising clock
  wire   riseOk   = clkSync_q[2] == 1'b0 && clkSync_q[1] == 1'b1;
  assign nextPos  = (bitPos_q == `RBM_FRAME_LAST) ? 12'h000 :
                    bitPos_q + 12'h001;
  // 32 bits per interleaved group of four bytes
  assign wordDone = riseOk && modeOk && (bitPos_q[4:0] == 5'h1F);
  assign pop      = wordDone && (bufCnt_q != 2'h0);
  assign chReady  = (bufCnt_q != 2'h2);
  assign push     = chValid && chReady;
  assign preStart = (rxModeSel == `RBM_MODE_HMVIP) ? `RBM_HMVIP_PRE :
                    `RBM_H100_PRE;
  assign postEnd  = (rxModeSel == `RBM_MODE_HMVIP) ? `RBM_HMVIP_POST :
                    `RBM_H100_POST;
  // Sync spans combined frame boundary
  assign syncNext = (nextPos >= preStart) || (nextPos <= postEnd);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      receive_interface_control_q <= `RBM_RECEIVE_INTERFACE_CONTROL_RESET;
      clkSync_q     <= 3'h0;
      buf0_q        <= 32'h0000_0000;
      buf1_q        <= 32'h0000_0000;
      bufCnt_q      <= 2'h0;
      bitPos_q      <= `RBM_FRAME_LAST;
      shift_q       <= 32'h0000_0000;
      underrun_q    <= 1'b0;
      rx_serial_out <= 1'b0;
      rx_frame_sync <= 1'b0;
    end else if (clkEn) begin
      clkSync_q <= {clkSync_q[1:0], rx_serial_clock};
      if (apbWrite)
        receive_interface_control_q <= pwdata[7:0];
      if (push && !pop) begin
        if (bufCnt_q == 2'h0)
          buf0_q <= {chByte0, chByte1, chByte2, chByte3};
        else
          buf1_q <= {chByte0, chByte1, chByte2, chByte3};
        bufCnt_q <= bufCnt_q + 2'h1;
      end else if (pop) begin
        buf0_q <= (bufCnt_q == 2'h2) ? buf1_q :
                  {chByte0, chByte1, chByte2, chByte3};
        if (push && bufCnt_q == 2'h2)
          buf1_q <= {chByte0, chByte1, chByte2, chByte3};
        if (!push)
          bufCnt_q <= bufCnt_q - 2'h1;
      end
      if (!modeOk) begin
        bitPos_q      <= `RBM_FRAME_LAST;
        rx_serial_out <= 1'b0;
        rx_frame_sync <= 1'b0;
      end else if (riseOk) begin
        bitPos_q      <= nextPos;
        rx_frame_sync <= syncNext;
        if (bitPos_q[4:0] == 5'h1F) begin
          // Byte-interleaved group: ch0 byte first, MSB first
          shift_q       <= {(bufCnt_q != 2'h0 ? buf0_q[30:0] : 31'h0),
                            1'b0};
          rx_serial_out <= (bufCnt_q != 2'h0) ? buf0_q[31] : 1'b0;
          if (bufCnt_q == 2'h0)
            underrun_q <= 1'b1;
        end else begin
          shift_q       <= {shift_q[30:0], 1'b0};
          rx_serial_out <= shift_q[31];
        end
      end
    end
  end
endmodule // rbm_rx_backplane_mux

/* File: verif/rbm_rx_backplane_mux_assertions.sv */
`timescale 1ns/1ps
module rbm_rx_backplane_mux_assertions (
  input logic        ref_clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic        rx_serial_clock,
  input logic        rx_serial_out,
  input logic        rx_frame_sync
);
  logic enQ;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      enQ <= 1'b0;
    else if (psel && penable && pwrite && paddr == 32'h0)
      enQ <= pwdata[2] & pwdata[1];
  end
  chk_data_launch: assert property (
    enQ && $changed(rx_serial_out) |-> rx_serial_clock) else $error("data");
  chk_sync_launch: assert property (
    enQ && $changed(rx_frame_sync) |-> rx_serial_clock) else $error("sync");
  chk_sync_min: assert property (
    $rose(rx_frame_sync) |-> rx_frame_sync[*8]) else $error("short sync");
  chk_sync_max: assert property (
    $rose(rx_frame_sync) |-> ##[1:70] !rx_frame_sync) else $error("long");
  chk_sync_gap: assert property (
    $fell(rx_frame_sync) |-> !rx_frame_sync[*8]) else $error("gap");
  chk_idle_quiet: assert property (
    (!enQ)[*3] |-> !rx_serial_out && !rx_frame_sync) else $error("idle");
endmodule // rbm_rx_backplane_mux_assertions

/* File: verif/rbm_backplane_model.sv */
`timescale 1ns/1ps
module rbm_backplane_model (
  output logic        rx_serial_clock,
  input  logic        rx_serial_out,
  input  logic        rx_frame_sync,
  output logic [31:0] rxWord,
  output logic [3:0]  syncBits
);
  initial begin
    rx_serial_clock = 1'b0;
    forever #62.5 rx_serial_clock = ~rx_serial_clock;
  end
  // Sample on the falling edge, mid bit
  always @(negedge rx_serial_clock) begin
    rxWord <= {rxWord[30:0], rx_serial_out};
    syncBits <= rx_frame_sync ? syncBits + 4'h1 : 4'h0;
  end
endmodule // rbm_backplane_model

/* File: verif/rbm_rx_backplane_mux_tb.sv */
`timescale 1ns/1ps
module rbm_rx_backplane_mux_tb;
  logic ref_clk, nrst, psel, penable, pwrite, chValid, pready, pslverr, err;
  logic chReady, rx_serial_clock, rx_serial_out, rx_frame_sync;
  logic [31:0] paddr, pwdata, prdata, rd, rxWord;
  logic [3:0] syncBits;
  int n_fail, cmp_count;
  rbm_rx_backplane_mux dut_u (.ref_clk, .nrst, .clkEn(1'b1), .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_serial_clock,
    .chByte0(8'hA5), .chByte1(8'h3C), .chByte2(8'h0F), .chByte3(8'hD2),
    .chValid, .chReady, .rx_serial_out, .rx_frame_sync);
  rbm_backplane_model bp_u (.rx_serial_clock, .rx_serial_out,
    .rx_frame_sync, .rxWord, .syncBits);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task cmp(input logic [31:0] e, g, input string s);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task frame(input logic [3:0] n, input int k, input string s);
    @(negedge rx_frame_sync);
    cmp({28'h0, n}, {28'h0, syncBits}, s);
    repeat (k) @(negedge rx_serial_clock);
    #1;
    cmp(32'hA53C0FD2, rxWord, s);
    $display("%s done", s);
  endtask
  task results;
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #720000;
    n_fail++;
    results;
  end
  initial begin
    {nrst, psel, penable, pwrite, chValid, paddr, pwdata} <= 69'h0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, 32'h0, 32'h0);
    cmp(32'h0, rd, "ctrl reset");
    apb(1'b0, 32'h8, 32'h0);
    cmp(32'h1, {rd[30:0], err}, "unmapped");
    chValid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmp(32'h0, {31'h0, chReady}, "buffer full");
    apb(1'b0, 32'h4, 32'h0);
    cmp(32'h2, rd, "status");
    apb(1'b1, 32'h0, 32'h6);
    apb(1'b0, 32'h0, 32'h0);
    cmp(32'h6, rd, "ctrl rw");
    $display("registers done");
    @(negedge rx_frame_sync);
    frame(4'h4, 30, "hmvip");
    apb(1'b1, 32'h0, 32'h7);
    frame(4'h2, 31, "h100");
    results;
  end
endmodule // rbm_rx_backplane_mux_tb
bind rbm_rx_backplane_mux rbm_rx_backplane_mux_assertions chk_u (.ref_clk,
  .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .rx_serial_clock,
  .rx_serial_out, .rx_frame_sync);
